// *** rtl/irm_defines.svh ***
// Timing constants and reset values for the infrared ASK carrier gate
`ifndef IRM_DEFINES_SVH
`define IRM_DEFINES_SVH

`define IRM_CLK_HZ 100000000
`define IRM_CARRIER_HZ 500000
`define IRM_CARRIER_TOL_HZ 25000
`define IRM_HALF_DIV (`IRM_CLK_HZ / (2 * `IRM_CARRIER_HZ))
// Rounded up so the shortest accepted half period stays inside the band
`define IRM_HALF_DIV_MIN ((`IRM_CLK_HZ + 2 * (`IRM_CARRIER_HZ + `IRM_CARRIER_TOL_HZ) - 1) / (2 * (`IRM_CARRIER_HZ + `IRM_CARRIER_TOL_HZ)))
`define IRM_HALF_DIV_MAX (`IRM_CLK_HZ / (2 * (`IRM_CARRIER_HZ - `IRM_CARRIER_TOL_HZ)))
`define IRM_MAX_BAUD 38400
`define IRM_BIT_NS (1000000000 / `IRM_MAX_BAUD)
`define IRM_BIT_CYC ((`IRM_BIT_NS + 9) / 10)

`endif

// *** rtl/irm_pkg.sv ***
// Types shared by the infrared ASK carrier gate
package irm_pkg;
   typedef enum logic [1:0] {
      IRM_IDLE = 2'b00,
      IRM_TX = 2'b01,
      IRM_DRAIN = 2'b10
   } irm_dir_t;

   typedef struct packed {
      logic led;
      logic rx_data;
      logic rx_valid;
      logic tx_busy;
   } irm_out_t;
endpackage

// *** rtl/irm_carrier_div.sv ***
// Free-running carrier divider with a ratio latched only at half-period ends
`timescale 1ns/1ps
`default_nettype none
`include "irm_defines.svh"
module irm_carrier_div #(
   parameter int W = 12
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_half_div,
   input wire logic i_hold,
   output logic o_carrier
);
   import irm_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] ratio;
      logic car;
   } irm_div_st_t;

   irm_div_st_t st_ff, nxt_st_ff;

   always_comb begin
      nxt_st_ff = st_ff;
      // Runs regardless of data; data never touches this counter
      if (st_ff.cnt >= st_ff.ratio - W'(1)) begin
         nxt_st_ff.cnt = '0;
         nxt_st_ff.car = ~st_ff.car;
         if (!i_hold && i_half_div != '0) begin
            nxt_st_ff.ratio = i_half_div;
         end
      end else begin
         nxt_st_ff.cnt = st_ff.cnt + W'(1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_ff <= '{cnt: '0, ratio: W'(`IRM_HALF_DIV), car: 1'b0};
      end else begin
         st_ff <= nxt_st_ff;
      end
   end

   assign o_carrier = st_ff.car;
endmodule
`default_nettype wire

// *** rtl/irm_ask_gate.sv ***
// Infrared ASK transmit gate with half-duplex receive blanking
`timescale 1ns/1ps
`default_nettype none
`include "irm_defines.svh"
// Behaviour
// - Mark data drives carrier onto LED
// - Space data holds LED off
// - Carrier runs free; data only gates
// - Mark is one, space is zero
// - Carrier fills whole mark bit
// - Carrier kept within 25 kHz nominal
// - Carrier NAND-gated with data
// - Half-duplex: receive blanked while transmit is selected; LED follows data in any direction
// - Local echo expected on receive path
// - Receiver output active low; invert it
module irm_ask_gate #(
   parameter int DIV_W = 12,
   parameter int GUARD_CYC = `IRM_BIT_CYC,
   parameter int GUARD_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_tx_data,
   input wire logic i_tx_dir,
   input wire logic [DIV_W-1:0] i_half_div,
   input wire logic i_rx_n,
   output irm_pkg::irm_out_t o_status,
   output logic o_led
);
   import irm_pkg::*;

   // Notes for users of this block:
   // - Carrier phase is unrelated to data edges, so the first and the last
   //   carrier pulse of a mark may come out shortened.
   // - The ratio input is read only while idle; a change during a transfer
   //   waits until the receive path is open again.
   // - Out-of-band ratios raise no flag; the nominal half period is used instead.
   // - Whole echoed characters are not removed here; the receive path is only
   //   blanked while the direction is transmit, and for one bit of space after
   //   the last mark, so a stop bit still in flight is not cut short.
   // - Receive data reads as zero while blanked; qualify it with the valid flag.
   // - Data, direction and receive pins pass two flip-flops before use.
   // - The ratio input comes from logic on this clock and is read directly.

   typedef struct packed {
      logic [1:0] tx_sync;
      logic [1:0] dir_sync;
      logic [1:0] rx_sync;
      irm_dir_t dir;
      logic [GUARD_W-1:0] guard;
      logic [DIV_W-1:0] div_sel;
      logic led;
      logic rx_data;
      logic rx_valid;
      logic tx_busy;
   } irm_st_t;

   irm_st_t st_ff, nxt_st_ff;
   logic carrier;

   // Reset state: LED dark, receive pin idle high, nominal ratio
   function automatic irm_st_t reset_state();
      irm_st_t s;
      s.tx_sync = 2'b00;
      s.dir_sync = 2'b00;
      s.rx_sync = 2'b11;
      s.dir = IRM_IDLE;
      s.guard = '0;
      s.div_sel = DIV_W'(`IRM_HALF_DIV);
      s.led = 1'b0;
      s.rx_data = 1'b0;
      s.rx_valid = 1'b0;
      s.tx_busy = 1'b0;
      reset_state = s;
   endfunction

   // Programmed ratio accepted only inside the tolerance band
   function automatic logic in_band(input logic [DIV_W-1:0] d);
      in_band = (d >= DIV_W'(`IRM_HALF_DIV_MIN)) && (d <= DIV_W'(`IRM_HALF_DIV_MAX));
   endfunction

   // Out-of-band requests fall back to the nominal half period
   function automatic logic [DIV_W-1:0] pick_ratio(input logic [DIV_W-1:0] d);
      if (in_band(d)) begin
         pick_ratio = d;
      end else begin
         pick_ratio = DIV_W'(`IRM_HALF_DIV);
      end
   endfunction

   // Two-stage shift for a pin from outside the clock domain
   function automatic logic [1:0] sync_step(input logic [1:0] s, input logic pin);
      sync_step = {s[0], pin};
   endfunction

   // Synchronised data level; mark is one, space is zero
   function automatic logic mark_bit(input logic [1:0] s);
      mark_bit = s[1];
   endfunction

   // Guard counter: cleared by a mark, saturates at the bit-time limit
   function automatic logic [GUARD_W-1:0] guard_step(input logic [GUARD_W-1:0] g, input logic mark);
      if (mark) begin
         guard_step = '0;
      end else if (g < GUARD_W'(GUARD_CYC)) begin
         guard_step = g + GUARD_W'(1);
      end else begin
         guard_step = g;
      end
   endfunction

   // True once space has lasted a full bit after the last mark
   function automatic logic guard_done(input logic [GUARD_W-1:0] g, input logic mark);
      guard_done = !mark && (g >= GUARD_W'(GUARD_CYC));
   endfunction

   // Any state but idle owns the optical path
   function automatic logic dir_busy(input irm_dir_t d);
      dir_busy = (d != IRM_IDLE);
   endfunction

   // NAND of data and carrier followed by an inverter
   function automatic logic gate_led(input logic mark, input logic car);
      logic nand_out;
      nand_out = ~(mark & car);
      gate_led = ~nand_out;
   endfunction

   // Receiver pin is low while carrier is heard; flip it, zero it when blanked
   function automatic logic rx_bit(input logic rx_n, input logic open);
      rx_bit = open ? ~rx_n : 1'b0;
   endfunction

   // Carrier runs on its own; data never reaches the divider
   irm_carrier_div #(
      .W(DIV_W)
   ) u_div (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_half_div(st_ff.div_sel),
      .i_hold(st_ff.tx_busy),
      .o_carrier(carrier)
   );

   always_comb begin
      nxt_st_ff = st_ff;

      // Pin synchronisers
      nxt_st_ff.tx_sync = sync_step(st_ff.tx_sync, i_tx_data);
      nxt_st_ff.dir_sync = sync_step(st_ff.dir_sync, i_tx_dir);
      nxt_st_ff.rx_sync = sync_step(st_ff.rx_sync, i_rx_n);

      // Ratio frozen during a transfer
      if (!st_ff.tx_busy) begin
         nxt_st_ff.div_sel = pick_ratio(i_half_div);
      end

      // Direction: idle, transmitting, then draining until one bit time of space follows the last mark
      case (st_ff.dir)
         IRM_IDLE: begin
            // Receive path open until transmit is asked for
            if (st_ff.dir_sync[1]) begin
               nxt_st_ff.dir = IRM_TX;
            end
         end

         IRM_TX: begin
            // Guard restarts on every mark so the final bit is fully sent
            nxt_st_ff.guard = guard_step(st_ff.guard, mark_bit(st_ff.tx_sync));
            if (!st_ff.dir_sync[1]) begin
               nxt_st_ff.dir = IRM_DRAIN;
            end
         end

         IRM_DRAIN: begin
            // Transmit may be asked for again before the drain ends
            nxt_st_ff.guard = guard_step(st_ff.guard, mark_bit(st_ff.tx_sync));
            if (st_ff.dir_sync[1]) begin
               nxt_st_ff.dir = IRM_TX;
            end else if (guard_done(st_ff.guard, mark_bit(st_ff.tx_sync))) begin
               nxt_st_ff.dir = IRM_IDLE;
            end
         end

         default: begin
            nxt_st_ff.dir = IRM_IDLE;
         end
      endcase
      // Busy follows the state being entered
      nxt_st_ff.tx_busy = dir_busy(nxt_st_ff.dir);

      // Mark gates the running carrier on for the whole bit; space holds it off
      nxt_st_ff.led = gate_led(mark_bit(st_ff.tx_sync), carrier);

      // Receive path: inverted, and blanked while the direction is transmit or draining
      nxt_st_ff.rx_valid = !dir_busy(st_ff.dir) && !st_ff.dir_sync[1];
      nxt_st_ff.rx_data = rx_bit(st_ff.rx_sync[1], nxt_st_ff.rx_valid);
   end

   // Every field registers on every edge; reset is synchronous
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_ff <= reset_state();
      end else begin
         st_ff <= nxt_st_ff;
      end
   end

   assign o_led = st_ff.led;
   assign o_status = '{led: st_ff.led,
                       rx_data: st_ff.rx_data,
                       rx_valid: st_ff.rx_valid,
                       tx_busy: st_ff.tx_busy};
endmodule
`default_nettype wire

// *** sim/irm_ask_gate_props.sv ***
// Port assertions for the carrier gate
`timescale 1ns/1ps
`default_nettype none
module irm_ask_gate_props (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_tx_data,
   input wire logic i_tx_dir,
   input wire logic i_rx_n,
   input wire irm_pkg::irm_out_t o_status,
   input wire logic o_led
);
   import irm_pkg::*;
   logic [7:0] hi_ff;
   always_ff @(posedge i_mclk) hi_ff <= o_led ? hi_ff + 8'h01 : 8'h00;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_SPACE: assert property (!$past(i_tx_data, 3) |-> !o_led) else $error("led in space");
   AST_FILL: assert property ($fell(o_led) |-> ##[1:106] (o_led || !$past(i_tx_data, 3)))
      else $error("mark gap");
   AST_HALF: assert property (o_led |-> hi_ff < 8'h6A) else $error("half long");
   AST_BLANK: assert property ($past(i_tx_dir, 3) |-> !o_status.rx_valid) else $error("no blank");
   AST_BUSY: assert property ($fell(o_status.rx_valid) |=> o_status.tx_busy) else $error("busy late");
   AST_ECHO: assert property (o_status.tx_busy |-> !o_status.rx_valid) else $error("echo");
   AST_RX: assert property (o_status.rx_valid && $past(o_status.rx_valid, 3) |->
      o_status.rx_data != $past(i_rx_n, 3)) else $error("rx data");
   AST_DRAIN: assert property ($fell(o_status.tx_busy) |-> !o_status.rx_valid ##1 o_status.rx_valid)
      else $error("rx back");
   cover property ($rose(o_led));
   cover property ($fell(o_status.tx_busy));
   cover property (o_status.rx_data);
endmodule
bind irm_ask_gate irm_ask_gate_props u_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_tx_data(i_tx_data),
   .i_tx_dir(i_tx_dir), .i_rx_n(i_rx_n), .o_status(o_status), .o_led(o_led));
`default_nettype wire

// *** sim/irm_far_model.sv ***
// Remote receiver that also hears the local echo
`timescale 1ns/1ps
`default_nettype none
module irm_far_model (
   input wire logic i_mclk,
   input wire logic i_led,
   input wire logic i_far,
   output logic o_rx_n
);
   int gap = 999;
   always @(posedge i_mclk) gap <= i_led === 1'b1 ? 0 : gap + 1;
   // No optical isolation here, so the bench never runs full duplex
   assign o_rx_n = !(i_far || gap < 208);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Bench for the carrier gate
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst = 1'b1, dir = 1'b0, far = 1'b0, txd = 1'b0, rxn, led;
   logic [11:0] div = 12'h064;
   logic [15:0] run = 16'h0000, last_run = 16'h0000;
   irm_pkg::irm_out_t st;
   int n_errors = 0, total_checks = 0, hi = 0, h0;
   always #5 clk = ~clk;
   always @(posedge clk) hi <= hi + int'(led);
   // Length of the last complete LED high run
   always @(posedge clk) begin
      run <= led ? run + 16'h0001 : 16'h0000;
      if (!led && run != 16'h0000) last_run <= run;
   end
   irm_ask_gate #(.GUARD_CYC(20)) dut (.i_mclk(clk), .i_rst(rst), .i_tx_data(txd), .i_tx_dir(dir),
      .i_half_div(div), .i_rx_n(rxn), .o_status(st), .o_led(led));
   irm_far_model fm (.i_mclk(clk), .i_led(led), .i_far(far), .o_rx_n(rxn));
   task automatic chk(string nm, logic e, logic g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chk_n(string nm, logic [15:0] e, logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s exp %0d got %0d", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_rx;
      @(posedge clk) far <= 1'b1;
      repeat (6) @(negedge clk);
      chk("rx_data", 1'b1, st.rx_data);
      $display("t_rx done");
   endtask
   task automatic t_tx;
      @(posedge clk) dir <= 1'b1;
      far <= 1'b0;
      repeat (5) @(negedge clk);
      chk("rx_valid", 1'b0, st.rx_valid);
      h0 = hi;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) txd <= i[0];
         repeat (2604) @(posedge clk);
      end
      @(posedge clk) txd <= 1'b0;
      dir <= 1'b0;
      repeat (10) @(negedge clk);
      chk("led_on", 1'b1, hi - h0 inside {[4900:5500]});
      chk("rx_echo", 1'b0, st.rx_data);
      chk("tx_busy", 1'b1, st.tx_busy);
      repeat (30) @(negedge clk);
      chk("rx_valid", 1'b1, st.rx_valid);
      $display("t_tx done");
   endtask
   task automatic t_div;
      @(posedge clk) div <= 12'h061;
      repeat (300) @(posedge clk);
      txd <= 1'b1;
      repeat (700) @(negedge clk);
      chk_n("half_97", 16'h0061, last_run);
      chk("st_led", led, st.led);
      @(posedge clk) div <= 12'h05F;
      repeat (500) @(negedge clk);
      chk_n("half_95", 16'h0064, last_run);
      @(posedge clk) txd <= 1'b0;
      div <= 12'h064;
      $display("t_div done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_rx();
      t_tx();
      t_div();
      wrap_up();
   end
   initial begin
      #400us;
      n_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
